// ===== design/hbf_pkg.sv
package hbf_pkg;
	localparam int NUM_BRIDGES = 3;
	localparam int HOLD_SYNC_LEN = 2;
	// mode pin codes: mode_select_2..0
	localparam logic [2:0] MODE_LIMIT_PHASES = 3'h0;
	localparam logic [2:0] MODE_LIMIT_BRIDGES = 3'h1;
	localparam logic [2:0] MODE_TRIP_PHASES = 3'h2;
	localparam logic [2:0] MODE_TRIP_BRIDGES = 3'h3;
	localparam int MODE_LATCHED_BIT = 1;
	localparam int MODE_BRIDGE_BIT = 0;
	// hold inputs idle high
	localparam logic HOLD_PREV_RESET = 1'b1;
	// bridge output drive codes: {hs_on, ls_on}
	localparam logic [1:0] GATE_OFF = 2'h0;
	localparam logic [1:0] GATE_LS = 2'h1;
	localparam logic [1:0] GATE_HS = 2'h2;
endpackage

// ===== design/hbf_bridge.sv
`timescale 1ns/1ps
// one half-bridge: latched trip, per-cycle limit, hold-edge clear
module hbf_bridge (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic run,
	input wire logic latched_mode,
	input wire logic pwm,
	input wire logic hold_n,
	input wire logic overcurrent_high,
	input wire logic overcurrent_low,
	output logic hold_rise,
	output logic tripped,
	output logic high_on,
	output logic low_on,
	output logic drive_en
);
	typedef struct packed {
		logic hold_prev;
		logic trip;
		logic hs_limit;
		logic ls_limit;
		logic pwm_prev;
		logic hs;
		logic ls;
		logic en;
	} hbf_bridge_state_t;

	hbf_bridge_state_t q;
	hbf_bridge_state_t next_q;
	logic new_cycle;

	always_comb begin
		next_q = q;
		hold_rise = hold_n && !q.hold_prev;
		new_cycle = pwm && !q.pwm_prev;
		next_q.hold_prev = hold_n;
		next_q.pwm_prev = pwm;
		// supply or thermal stops leave a latched trip in place; only a hold release clears it
		if (hold_rise) begin
			next_q.trip = 1'b0;
		end
		if (run && latched_mode && (overcurrent_high || overcurrent_low)) begin
			next_q.trip = 1'b1;
		end
		// limits end at the next rising pwm edge, which starts a new cycle
		if (new_cycle || latched_mode || !run) begin
			next_q.hs_limit = 1'b0;
			next_q.ls_limit = 1'b0;
		end
		if (run && !latched_mode && overcurrent_high) begin
			next_q.hs_limit = 1'b1;
		end
		if (run && !latched_mode && overcurrent_low) begin
			next_q.ls_limit = 1'b1;
		end
		next_q.en = run && hold_n && !next_q.trip;
		if (next_q.hs_limit) begin
			next_q.hs = 1'b0;
			next_q.ls = 1'b1;
		end else if (next_q.ls_limit) begin
			next_q.hs = 1'b0;
			next_q.ls = 1'b0;
		end else begin
			next_q.hs = pwm;
			next_q.ls = !pwm;
		end
		if (!next_q.en) begin
			next_q.hs = 1'b0;
			next_q.ls = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// a low reset value would fake a hold release on the first edge
			q <= '{hold_prev: hbf_pkg::HOLD_PREV_RESET, default: 1'b0};
		end else if (ce) begin
			q <= next_q;
		end
	end

	// next value, so the indicator follows a trip or a clear on the same edge
	assign tripped = next_q.trip;
	assign high_on = q.hs;
	assign low_on = q.ls;
	assign drive_en = q.en;
endmodule

// ===== design/hbf_fault_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - power-up clears overcurrent state; outputs idle until gate and logic supplies good.
// - any supply below threshold: all bridges high impedance, shutdown indicator low.
// - recovery from undervoltage is automatic once all supplies are good again.
// - each bridge has an active-low hold; low forces both transistors off.
// - hold rising edge clears that bridge's latched trip and releases the indicator.
// - thermal shutdown clears only after all three holds have risen.
// - mode pins select per-cycle limiting or latched trip; bit 0 only reports three-phase or half-bridge use.
// - per-cycle mode, high-side overcurrent: high off, low on until next cycle.
// - per-cycle mode, low-side overcurrent: both off until next cycle.
// - latched mode: overcurrent trips the bridge until its hold pulses.
// - indicator and warning outputs encode normal, warning, shutdown, both.
module hbf_fault_ctrl #(
	parameter int BRIDGES = hbf_pkg::NUM_BRIDGES
) (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	input wire logic GATE_DRIVE_SUPPLY_OK,
	input wire logic LOGIC_SUPPLY_OK,
	input wire logic [BRIDGES-1:0] BOOTSTRAP_OK,
	input wire logic [2:0] MODE_SELECT,
	input wire logic [BRIDGES-1:0] PWM,
	input wire logic [BRIDGES-1:0] HOLD_N,
	input wire logic [BRIDGES-1:0] OVERCURRENT_HIGH,
	input wire logic [BRIDGES-1:0] OVERCURRENT_LOW,
	input wire logic OVERTEMP_WARN,
	input wire logic OVERTEMP_TRIP,
	output logic [BRIDGES-1:0] HIGH_ON,
	output logic [BRIDGES-1:0] LOW_ON,
	output logic [BRIDGES-1:0] DRIVE_EN,
	output logic LATCHED_MODE,
	output logic INDEPENDENT_BRIDGE_USE,
	output logic FAULT_N,
	output logic THERMAL_WARNING_N
);
	if (BRIDGES != hbf_pkg::NUM_BRIDGES) begin : gen_bad_count
		$error("bridge count must be three");
	end

	typedef struct packed {
		logic powered;
		logic thermal_shutdown;
		logic [BRIDGES-1:0] seen_rise;
		logic fault_n;
		logic warn_n;
	} hbf_state_t;

	hbf_state_t q;
	hbf_state_t next_q;
	logic supply_low_guard;
	logic run;
	logic latched;
	logic [BRIDGES-1:0] hold_rise;
	logic [BRIDGES-1:0] tripped;

	// mode bit 1 picks the latched trip; bit 0 only reports bridge use
	assign latched = MODE_SELECT[hbf_pkg::MODE_LATCHED_BIT];
	assign supply_low_guard = !GATE_DRIVE_SUPPLY_OK || !LOGIC_SUPPLY_OK || !(&BOOTSTRAP_OK);
	// drive gated combinationally so undervoltage acts without a cycle of delay
	assign run = q.powered && !supply_low_guard && !q.thermal_shutdown;

	genvar g;
	generate
		for (g = 0; g < BRIDGES; g++) begin : gen_bridge
			logic hs;
			logic ls;
			logic en;
			hbf_bridge u_bridge (
				.clk(MCLK),
				.rst_n(RESET_N),
				.ce(CLK_EN),
				.run(run),
				.latched_mode(latched),
				.pwm(PWM[g]),
				.hold_n(HOLD_N[g]),
				.overcurrent_high(OVERCURRENT_HIGH[g]),
				.overcurrent_low(OVERCURRENT_LOW[g]),
				.hold_rise(hold_rise[g]),
				.tripped(tripped[g]),
				.high_on(hs),
				.low_on(ls),
				.drive_en(en)
			);
			assign HIGH_ON[g] = hs && run;
			assign LOW_ON[g] = ls && run;
			assign DRIVE_EN[g] = en && run;
		end
	endgenerate

	always_comb begin
		next_q = q;
		// power-up: released only once gate and logic supplies are good
		if (GATE_DRIVE_SUPPLY_OK && LOGIC_SUPPLY_OK) begin
			next_q.powered = 1'b1;
		end
		next_q.seen_rise = q.seen_rise | hold_rise;
		if (&next_q.seen_rise) begin
			next_q.thermal_shutdown = 1'b0;
			next_q.seen_rise = '0;
		end
		// a new trip wins over a clear in the same cycle
		if (OVERTEMP_TRIP) begin
			next_q.thermal_shutdown = 1'b1;
			next_q.seen_rise = '0;
		end
		next_q.fault_n = !(supply_low_guard || next_q.thermal_shutdown || (|tripped));
		next_q.warn_n = !OVERTEMP_WARN;
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			q <= '0;
		end else if (CLK_EN) begin
			q <= next_q;
		end
	end

	assign FAULT_N = q.fault_n;
	assign THERMAL_WARNING_N = q.warn_n;
	assign LATCHED_MODE = latched;
	assign INDEPENDENT_BRIDGE_USE = MODE_SELECT[hbf_pkg::MODE_BRIDGE_BIT];
endmodule

// ===== bench/hbf_chk.sv
`timescale 1ns/1ps
module hbf_chk (
	input logic MCLK,
	input logic RESET_N,
	input logic GATE_DRIVE_SUPPLY_OK,
	input logic LOGIC_SUPPLY_OK,
	input logic [2:0] MODE_SELECT,
	input logic [2:0] HOLD_N,
	input logic [2:0] OVERCURRENT_HIGH,
	input logic [2:0] OVERCURRENT_LOW,
	input logic OVERTEMP_WARN,
	input logic OVERTEMP_TRIP,
	input logic [2:0] HIGH_ON,
	input logic [2:0] LOW_ON,
	input logic [2:0] DRIVE_EN,
	input logic LATCHED_MODE,
	input logic FAULT_N,
	input logic THERMAL_WARNING_N
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESET_N);
	uv_drive_off_a: assert property (!(GATE_DRIVE_SUPPLY_OK && LOGIC_SUPPLY_OK) |-> {HIGH_ON, LOW_ON, DRIVE_EN} == 9'h0)
		else $error("drive in undervoltage");
	uv_fault_a: assert property (!(GATE_DRIVE_SUPPLY_OK && LOGIC_SUPPLY_OK) |=> !FAULT_N)
		else $error("fault not shown");
	hold_off_a: assert property (!HOLD_N[0] |=> !DRIVE_EN[0])
		else $error("drive while held");
	limit_high_a: assert property (!LATCHED_MODE && OVERCURRENT_HIGH[1] && DRIVE_EN[1] |=> !HIGH_ON[1])
		else $error("high side stayed on");
	limit_low_a: assert property (!LATCHED_MODE && OVERCURRENT_LOW[1] && !OVERCURRENT_HIGH[1] && DRIVE_EN[1]
		|=> !HIGH_ON[1] && !LOW_ON[1])
		else $error("low side limit not applied");
	latch_trip_a: assert property (LATCHED_MODE && OVERCURRENT_HIGH[0] && DRIVE_EN[0] |=> !DRIVE_EN[0] && !FAULT_N)
		else $error("no latched trip");
	thermal_off_a: assert property (OVERTEMP_TRIP |=> !FAULT_N && DRIVE_EN == 3'h0)
		else $error("no thermal stop");
	warn_out_a: assert property (OVERTEMP_WARN |=> !THERMAL_WARNING_N)
		else $error("warning missing");
	mode_pin_a: assert property (LATCHED_MODE == MODE_SELECT[1])
		else $error("mode wrong");
endmodule
bind hbf_fault_ctrl hbf_chk hbf_chk_inst (.*);

// ===== bench/hbf_host.sv
`timescale 1ns/1ps
module hbf_host (
	input logic mclk,
	input logic [2:0] hold_req,
	output logic [2:0] pwm,
	output logic [2:0] hold_n
);
	logic [1:0] cnt = 2'h0;
	always @(posedge mclk) cnt <= cnt + 2'h1;
	// 75% duty, low side on one cycle in four to keep bootstrap charged
	assign pwm = {3{cnt != 2'h3}};
	assign hold_n = ~hold_req;
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic MCLK = 1'b0, RESET_N = 1'b0, g = 1'b1, l = 1'b1, w = 1'b0, t = 1'b0, f, wn, lm, ib;
	logic [2:0] m = 3'h0, oh = 3'h0, ol = 3'h0, hr = 3'h0, b = 3'h7, p, hn, hi, lo, de;
	int errors = 0, comparisons = 0, cycles = 0;
	always #10 MCLK = ~MCLK;
	hbf_host hbf_host_inst (.mclk(MCLK), .hold_req(hr), .pwm(p), .hold_n(hn));
	hbf_fault_ctrl hbf_fault_ctrl_inst (.MCLK(MCLK), .RESET_N(RESET_N), .CLK_EN(1'b1), .GATE_DRIVE_SUPPLY_OK(g),
		.LOGIC_SUPPLY_OK(l), .BOOTSTRAP_OK(b), .MODE_SELECT(m), .PWM(p), .HOLD_N(hn), .OVERCURRENT_HIGH(oh),
		.OVERCURRENT_LOW(ol), .OVERTEMP_WARN(w), .OVERTEMP_TRIP(t), .HIGH_ON(hi), .LOW_ON(lo), .DRIVE_EN(de),
		.LATCHED_MODE(lm), .INDEPENDENT_BRIDGE_USE(ib), .FAULT_N(f), .THERMAL_WARNING_N(wn));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge MCLK);
	endtask
	// holds are released together so the rise lands on one edge
	task automatic pulse(input logic [2:0] k);
		hr = k;
		step(1);
		hr = 3'h0;
		step(4);
	endtask
	task automatic print_verdict;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge MCLK) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			print_verdict;
		end
	end
	initial begin
		step(10);
		RESET_N = 1'b1;
		step(4);
		chk({f, wn, de}, 8'h1f);
		l = 1'b0;
		#1 chk(de, 8'h0);
		step(1);
		chk(f, 8'h0);
		l = 1'b1;
		step(3);
		chk({f, de}, 8'hf);
		b = 3'h6;
		#1 chk(de, 8'h0);
		step(1);
		chk(f, 8'h0);
		b = 3'h7;
		step(3);
		chk({f, de}, 8'hf);
		w = 1'b1;
		step(1);
		chk({f, wn}, 8'h2);
		w = 1'b0;
		t = 1'b1;
		step(1);
		t = 1'b0;
		step(1);
		chk({f, de}, 8'h0);
		pulse(3'h3);
		chk(f, 8'h0);
		pulse(3'h4);
		chk({f, de}, 8'hf);
		hr = 3'h1;
		step(1);
		chk(de, 8'h6);
		pulse(3'h0);
		m = hbf_pkg::MODE_TRIP_BRIDGES;
		step(1);
		chk({lm, ib}, 8'h3);
		oh = 3'h1;
		step(1);
		oh = 3'h0;
		step(3);
		chk({f, de}, 8'h6);
		pulse(3'h1);
		chk({f, de}, 8'hf);
		m = hbf_pkg::MODE_LIMIT_PHASES;
		for (int i = 0; i < 2; i++) begin
			while (hbf_host_inst.cnt != 2'h1) step(1);
			oh = i ? 3'h0 : 3'h2;
			ol = i ? 3'h2 : 3'h0;
			step(1);
			{oh, ol} = 6'h0;
			chk({hi[1], lo[1]}, i ? 8'h0 : 8'h1);
			chk(f, 8'h1);
			chk({lm, ib}, 8'h0);
		end
		print_verdict;
	end
endmodule
